/* File: core/pkt_defines.svh */
// Offsets, field positions, reset values and timing counts of the packetizer
`ifndef PKT_DEFINES_SVH
`define PKT_DEFINES_SVH

`define REG_CTRL      8'h00
`define REG_FORCE     8'h04
`define REG_PACK      8'h08
`define REG_DELIM     8'h0C
`define REG_INACT     8'h10
`define REG_STATUS    8'h14
`define REG_DEST0     8'h20
`define REG_DEST1     8'h24
`define REG_DEST2     8'h28
`define REG_DEST3     8'h2C

`define CTRL_DP_MSB   1
`define CTRL_DP_LSB   0
`define CTRL_D1_EN    2
`define CTRL_D2_EN    3
`define CTRL_MODE_MSB 6
`define CTRL_MODE_LSB 4
`define CTRL_DEST_MSB 11
`define CTRL_DEST_LSB 8

`define DEST_EN_RST   4'h1
`define BUF_BYTES     11'h400
`define MS_NS         1000000
`define CLK_NS        20
`define MS_CYCLES     (`MS_NS / `CLK_NS)

`endif

/* File: core/pkt_pkg.sv */
// Types shared by the packetizer modules
package pkt_pkg;

	typedef enum logic [1:0] {
		DP_NOTHING = 2'b00,
		DP_PLUS1   = 2'b01,
		DP_PLUS2   = 2'b10,
		DP_STRIP   = 2'b11
	} delim_proc_t;

	typedef enum logic [2:0] {
		CM_STARTUP   = 3'b000,
		CM_ANY_NONE  = 3'b001,
		CM_ANY_INACT = 3'b010,
		CM_DSR_ONOFF = 3'b011,
		CM_DSR_NONE  = 3'b100,
		CM_DCD_ONOFF = 3'b101,
		CM_DCD_NONE  = 3'b110
	} conn_mode_t;

	typedef struct packed {
		delim_proc_t      dproc;
		logic             d1_en;
		logic             d2_en;
		conn_mode_t       mode;
		logic [3:0]       dest_en;
		logic [15:0]      force_ms;
		logic [15:0]      inact_ms;
		logic [10:0]      pack_len;
		logic [7:0]       d1;
		logic [7:0]       d2;
		logic [3:0][31:0] dest;
	} cfg_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} beat_t;

	typedef struct packed {
		cfg_t        cfg;
		logic [10:0] wp;
		logic [10:0] rp;
		logic [10:0] pend_end;
		logic [10:0] frame_cnt;
		logic        pend;
		logic        flush_wait;
		logic        d1_seen;
		logic [1:0]  trail;
		logic [15:0] ft_ms;
		logic [31:0] rdata;
		logic        tx_valid;
		beat_t       tx;
	} pkt_state_t;

	typedef struct packed {
		logic        dsr_m;
		logic        dsr_s;
		logic        dsr_d;
		logic        dcd_m;
		logic        dcd_s;
		logic        dcd_d;
		logic        open;
		logic [15:0] idle_ms;
	} conn_state_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} tick_state_t;

endpackage

/* File: core/ms_tick.sv */
// Millisecond enable pulse divided down from the system clock
`timescale 1ns/100ps
module ms_tick #(
	parameter int CYCLES = 50000
) (
	input  wire logic clock,
	input  wire logic reset_n,
	output logic      tick
);
	pkt_pkg::tick_state_t q;
	pkt_pkg::tick_state_t s;

	always_comb
	begin
		s = q;
		s.tick = 1'b0;
		if (q.cnt == 32'(CYCLES - 1))
		begin
			s.cnt = 32'h0000_0000;
			s.tick = 1'b1;
		end
		else
			s.cnt = q.cnt + 32'h0000_0001;
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
			q <= '0;
		else
			q <= s;
	end

	assign tick = q.tick;
endmodule // ms_tick

/* File: core/conn_ctrl.sv */
// Outbound connection open/close decisions from traffic and modem lines
`timescale 1ns/100ps
`include "pkt_defines.svh"
module conn_ctrl (
	input  wire logic                clock,
	input  wire logic                reset_n,
	input  wire logic                ms_tick,
	input  wire pkt_pkg::conn_mode_t mode,
	input  wire logic [15:0]         inact_ms,
	input  wire logic                rx_act,
	input  wire logic                out_act,
	input  wire logic                dsr,
	input  wire logic                dcd,
	output logic                     conn_open
);
	pkt_pkg::conn_state_t q;
	pkt_pkg::conn_state_t s;
	logic dsr_rise;
	logic dsr_fall;
	logic dcd_rise;
	logic dcd_fall;
	logic idle_hit;

	assign dsr_rise = q.dsr_s & ~q.dsr_d;
	assign dsr_fall = ~q.dsr_s & q.dsr_d;
	assign dcd_rise = q.dcd_s & ~q.dcd_d;
	assign dcd_fall = ~q.dcd_s & q.dcd_d;
	assign idle_hit = (inact_ms != 16'h0000) && (q.idle_ms >= inact_ms);

	always_comb
	begin
		s = q;
		s.dsr_m = dsr;
		s.dsr_s = q.dsr_m;
		s.dsr_d = q.dsr_s;
		s.dcd_m = dcd;
		s.dcd_s = q.dcd_m;
		s.dcd_d = q.dcd_s;
		// Traffic either way restarts the idle count; saturates
		if (rx_act || out_act)
			s.idle_ms = 16'h0000;
		else if (ms_tick && q.idle_ms != 16'hFFFF)
			s.idle_ms = q.idle_ms + 16'h0001;
		case (mode)
			pkt_pkg::CM_STARTUP:
				s.open = 1'b1;
			pkt_pkg::CM_ANY_NONE:
				if (rx_act)
					s.open = 1'b1;
			pkt_pkg::CM_ANY_INACT:
				if (rx_act)
					s.open = 1'b1;
				else if (idle_hit)
					s.open = 1'b0;
			pkt_pkg::CM_DSR_ONOFF:
				if (dsr_rise)
					s.open = 1'b1;
				else if (dsr_fall)
					s.open = 1'b0;
			pkt_pkg::CM_DSR_NONE:
				if (dsr_rise)
					s.open = 1'b1;
			pkt_pkg::CM_DCD_ONOFF:
				if (dcd_rise)
					s.open = 1'b1;
				else if (dcd_fall)
					s.open = 1'b0;
			pkt_pkg::CM_DCD_NONE:
				if (dcd_rise)
					s.open = 1'b1;
			default:
				s.open = 1'b0;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
			q <= '0;
		else
			q <= s;
	end

	assign conn_open = q.open;

	startup_open_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		mode == pkt_pkg::CM_STARTUP |=> conn_open)
		else $error("startup mode did not hold the connection open");

	any_char_open_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(mode == pkt_pkg::CM_ANY_NONE || mode == pkt_pkg::CM_ANY_INACT)
		&& rx_act |=> conn_open)
		else $error("first character did not open the connection");

	dsr_close_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		mode == pkt_pkg::CM_DSR_ONOFF && $fell(q.dsr_s) |=> !conn_open)
		else $error("DSR off did not close the connection");

	dcd_open_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(mode == pkt_pkg::CM_DCD_ONOFF || mode == pkt_pkg::CM_DCD_NONE)
		&& $rose(q.dcd_s) |=> conn_open)
		else $error("DCD on did not open the connection");

	inact_close_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		mode == pkt_pkg::CM_ANY_INACT && !rx_act && inact_ms != 16'h0000
		&& q.idle_ms >= inact_ms |=> !conn_open)
		else $error("inactivity timeout did not close the connection");

	inact_cov_c: cover property (@(posedge clock) disable iff (!reset_n)
		mode == pkt_pkg::CM_ANY_INACT && $fell(conn_open));
endmodule // conn_ctrl

/* File: core/serial_packetizer.sv */
// Serial-to-network packetizer: 1 KB buffer, flush decisions, register port
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "pkt_defines.svh"
module serial_packetizer #(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [7:0]       addr,
	input  wire logic [31:0]      wdata,
	input  wire logic             wr,
	input  wire logic             rd,
	output logic [31:0]           rdata,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_data,
	output logic                  rx_ready,
	input  wire logic             out_act,
	input  wire logic             dsr,
	input  wire logic             dcd,
	output logic                  tx_valid,
	output pkt_pkg::beat_t        tx_beat,
	input  wire logic             tx_ready,
	output logic                  conn_open,
	output logic [3:0]            dest_open,
	output logic [3:0][31:0]      dest_addr
);
	pkt_pkg::pkt_state_t q;
	pkt_pkg::pkt_state_t s;
	logic [7:0]  mem [0:1023];
	logic [7:0]  mem_rd;
	logic        tick;
	logic        acc;
	logic        is_d1;
	logic        is_d2;
	logic        match;
	logic [10:0] cnt_inc;
	logic [10:0] occ;
	logic        done;
	logic        wr_en;
	logic        retract;
	logic        dl_flush;
	logic        len_flush;
	logic        full_flush;
	logic        ft_flush;
	logic        flush;
	logic        commit;

	ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_tick (
		.clock   (clock),
		.reset_n (reset_n),
		.tick    (tick)
	);

	conn_ctrl u_conn (
		.clock     (clock),
		.reset_n   (reset_n),
		.ms_tick   (tick),
		.mode      (q.cfg.mode),
		.inact_ms  (q.cfg.inact_ms),
		.rx_act    (acc),
		.out_act   (out_act),
		.dsr       (dsr),
		.dcd       (dcd),
		.conn_open (conn_open)
	);

	assign occ = q.wp - q.rp;
	// Back-pressure only when every byte slot is taken
	assign rx_ready = (occ != `BUF_BYTES);
	assign acc = rx_valid && rx_ready;
	// Delimiting is off unless delimiter one is enabled
	assign is_d1 = q.cfg.d1_en && (rx_data == q.cfg.d1);
	assign is_d2 = q.cfg.d1_en && q.cfg.d2_en && q.d1_seen
		&& (rx_data == q.cfg.d2);
	assign match = q.cfg.d2_en ? is_d2 : is_d1;
	assign cnt_inc = q.frame_cnt + 11'h001;
	assign done = q.tx_valid && tx_ready && q.tx.last;
	assign mem_rd = mem[q.rp[9:0]];

	always_comb
	begin
		s = q;
		wr_en = 1'b0;
		retract = 1'b0;
		dl_flush = 1'b0;
		len_flush = 1'b0;
		full_flush = 1'b0;
		ft_flush = 1'b0;
		commit = 1'b0;
		s.rdata = 32'h0000_0000;
		if (acc)
		begin
			s.d1_seen = is_d1;
			if (q.trail != 2'b00)
			begin
				wr_en = 1'b1;
				s.trail = q.trail - 2'b01;
				dl_flush = (q.trail == 2'b01);
			end
			else if (match)
			begin
				case (q.cfg.dproc)
					pkt_pkg::DP_PLUS1:
					begin
						wr_en = 1'b1;
						s.trail = 2'b01;
					end
					pkt_pkg::DP_PLUS2:
					begin
						wr_en = 1'b1;
						s.trail = 2'b10;
					end
					pkt_pkg::DP_STRIP:
					begin
						// With delimiter two enabled, delimiter one already sits in the frame; take it back
						dl_flush = 1'b1;
						retract = q.cfg.d2_en && (q.frame_cnt != 11'h000);
					end
					default:
					begin
						wr_en = 1'b1;
						dl_flush = 1'b1;
					end
				endcase
			end
			else
				wr_en = 1'b1;
		end
		if (wr_en)
		begin
			s.wp = q.wp + 11'h001;
			s.frame_cnt = cnt_inc;
			len_flush = (q.cfg.pack_len != 11'h000)
				&& (cnt_inc == q.cfg.pack_len);
			full_flush = (cnt_inc == `BUF_BYTES);
		end
		if (retract)
		begin
			s.wp = q.wp - 11'h001;
			s.frame_cnt = q.frame_cnt - 11'h001;
		end
		// Timer runs from the first byte of a frame
		if (q.frame_cnt == 11'h000)
			s.ft_ms = 16'h0000;
		else if (tick && q.cfg.force_ms != 16'h0000)
		begin
			s.ft_ms = q.ft_ms + 16'h0001;
			ft_flush = (s.ft_ms >= q.cfg.force_ms);
		end
		flush = dl_flush || len_flush || full_flush || ft_flush
			|| q.flush_wait;
		if (q.tx_valid && tx_ready)
			s.tx_valid = 1'b0;
		if (done)
			s.pend = 1'b0;
		// Draining stalls on the network side: one slow peer paces all
		if (q.pend && conn_open && q.rp != q.pend_end
			&& (!q.tx_valid || tx_ready))
		begin
			s.tx_valid = 1'b1;
			s.tx.data = mem_rd;
			s.tx.last = ((q.rp + 11'h001) == q.pend_end);
			s.rp = q.rp + 11'h001;
		end
		// Only one frame is queued for the network; a later flush waits
		if (flush && s.frame_cnt != 11'h000)
		begin
			if (!s.pend)
			begin
				commit = 1'b1;
				s.pend = 1'b1;
				s.pend_end = s.wp;
				s.frame_cnt = 11'h000;
				s.ft_ms = 16'h0000;
				s.trail = 2'b00;
				s.flush_wait = 1'b0;
			end
			else
				s.flush_wait = 1'b1;
		end
		else
			s.flush_wait = 1'b0;
		if (wr)
		begin
			case (addr)
				`REG_CTRL:
				begin
					s.cfg.dproc = pkt_pkg::delim_proc_t'(
						wdata[`CTRL_DP_MSB:`CTRL_DP_LSB]);
					s.cfg.d1_en = wdata[`CTRL_D1_EN];
					s.cfg.d2_en = wdata[`CTRL_D2_EN];
					s.cfg.mode = pkt_pkg::conn_mode_t'(
						wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
					s.cfg.dest_en = wdata[`CTRL_DEST_MSB:`CTRL_DEST_LSB];
				end
				`REG_FORCE: s.cfg.force_ms = wdata[15:0];
				`REG_PACK:  s.cfg.pack_len = wdata[10:0];
				`REG_DELIM:
				begin
					s.cfg.d1 = wdata[7:0];
					s.cfg.d2 = wdata[15:8];
				end
				`REG_INACT: s.cfg.inact_ms = wdata[15:0];
				`REG_DEST0: s.cfg.dest[0] = wdata;
				`REG_DEST1: s.cfg.dest[1] = wdata;
				`REG_DEST2: s.cfg.dest[2] = wdata;
				`REG_DEST3: s.cfg.dest[3] = wdata;
				default: ;
			endcase
		end
		if (rd)
		begin
			case (addr)
				`REG_CTRL:
					s.rdata = {20'h0_0000, q.cfg.dest_en, 1'b0, q.cfg.mode,
						q.cfg.d2_en, q.cfg.d1_en, q.cfg.dproc};
				`REG_FORCE:  s.rdata = {16'h0000, q.cfg.force_ms};
				`REG_PACK:   s.rdata = {21'h00_0000, q.cfg.pack_len};
				`REG_DELIM:
					s.rdata = {16'h0000, q.cfg.d2, q.cfg.d1};
				`REG_INACT:  s.rdata = {16'h0000, q.cfg.inact_ms};
				`REG_STATUS:
					s.rdata = {2'h0, occ, q.flush_wait, q.pend, conn_open,
						5'h00, q.frame_cnt};
				`REG_DEST0:  s.rdata = q.cfg.dest[0];
				`REG_DEST1:  s.rdata = q.cfg.dest[1];
				`REG_DEST2:  s.rdata = q.cfg.dest[2];
				`REG_DEST3:  s.rdata = q.cfg.dest[3];
				default:     s.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			q <= '0;
			q.cfg.dest_en <= `DEST_EN_RST;
		end
		else
			q <= s;
	end

	// Kept apart from the state struct so it maps onto block RAM
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem[q.wp[9:0]] <= rx_data;
	end

	assign rdata = q.rdata;
	assign tx_valid = q.tx_valid;
	assign tx_beat = q.tx;
	assign dest_open = {4{conn_open}} & q.cfg.dest_en;
	assign dest_addr = q.cfg.dest;

	force_off_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		q.cfg.force_ms == 16'h0000 |-> !ft_flush)
		else $error("timer flush with force-transmit disabled");

	hold_full_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(q.wp - q.rp) == `BUF_BYTES |-> !rx_ready && !wr_en)
		else $error("byte accepted into a full buffer");

	full_flush_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		wr_en && q.frame_cnt == 11'h3FF |-> flush
		##1 (q.frame_cnt == 11'h000 || q.flush_wait))
		else $error("full buffer did not end the frame");

	pack_len_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		wr_en && q.cfg.pack_len != 11'h000 && cnt_inc == q.cfg.pack_len
		|-> len_flush)
		else $error("packing length reached without flush");

	trail_done_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		acc && q.trail == 2'b01 |-> wr_en && dl_flush)
		else $error("trailing byte did not end the frame");

	strip_drop_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		acc && q.trail == 2'b00 && match
		&& q.cfg.dproc == pkt_pkg::DP_STRIP |-> !wr_en && dl_flush)
		else $error("stripped delimiter was stored");

	plain_delim_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		acc && q.trail == 2'b00 && match
		&& q.cfg.dproc == pkt_pkg::DP_NOTHING |-> wr_en && dl_flush)
		else $error("delimiter not kept or not flushed");

	frame_restart_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		commit |=> q.frame_cnt == 11'h000 && q.ft_ms == 16'h0000
		&& q.pend && q.pend_end == $past(s.wp))
		else $error("frame end did not restart the next frame");

	rd_data_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		rd && addr == `REG_PACK |=> rdata[10:0] == $past(q.cfg.pack_len))
		else $error("register read data wrong");

	delim_cov_c: cover property (@(posedge clock) disable iff (!reset_n)
		dl_flush && commit);
	len_cov_c: cover property (@(posedge clock) disable iff (!reset_n)
		len_flush && commit);
	timer_cov_c: cover property (@(posedge clock) disable iff (!reset_n)
		ft_flush && commit);
	drain_cov_c: cover property (@(posedge clock) disable iff (!reset_n)
		done ##1 q.pend);
endmodule // serial_packetizer

/* File: bench/net_sink.sv */
// Network-side consumer model: records every beat and can stall
`timescale 1ns/100ps
module net_sink (
	input  wire logic           clock,
	input  wire logic           reset_n,
	input  wire logic           slow,
	input  wire logic           tx_valid,
	input  wire pkt_pkg::beat_t tx_beat,
	output logic                tx_ready
);
	logic [8:0] beats[$];
	logic       phase_ff;

	// A slow peer takes every other cycle and so paces the whole link
	assign tx_ready = !slow || phase_ff;

	always @(posedge clock)
	begin
		if (!reset_n)
			phase_ff <= 1'b0;
		else
			phase_ff <= !phase_ff;
		if (reset_n && tx_valid && tx_ready)
			beats.push_back(tx_beat);
	end
endmodule // net_sink

/* File: bench/serial_to_net_packetizer_tb.sv */
// Self-checking bench for the serial-to-network packetizer
`timescale 1ns/100ps
`include "pkt_defines.svh"
module serial_to_net_packetizer_tb;
	logic             clock;
	logic             reset_n;
	logic [7:0]       addr;
	logic [31:0]      wdata;
	logic             wr;
	logic             rd;
	logic [31:0]      rdata;
	logic             rx_valid;
	logic [7:0]       rx_data;
	logic             rx_ready;
	logic             out_act;
	logic             dsr;
	logic             dcd;
	logic             tx_valid;
	pkt_pkg::beat_t   tx_beat;
	logic             tx_ready;
	logic             conn_open;
	logic [3:0]       dest_open;
	logic [3:0][31:0] dest_addr;
	logic             slow;
	logic [31:0]      v;
	logic [8:0]       q[$];
	int               n_errors;
	int               cmp_count;

	// Short millisecond so timer scenarios stay brief
	serial_packetizer #(.MS_CYCLES(10)) i_serial_packetizer (
		.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .out_act(out_act),
		.dsr(dsr), .dcd(dcd), .tx_valid(tx_valid), .tx_beat(tx_beat),
		.tx_ready(tx_ready), .conn_open(conn_open),
		.dest_open(dest_open), .dest_addr(dest_addr)
	);

	net_sink i_net_sink (
		.clock(clock), .reset_n(reset_n), .slow(slow),
		.tx_valid(tx_valid), .tx_beat(tx_beat), .tx_ready(tx_ready)
	);

	initial
	begin
		clock = 1'b0;
		forever
			#10 clock = !clock;
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Holds the byte until the buffer has room, as a serial source must
	task automatic send(input logic [7:0] b);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_data <= b;
		do
			@(negedge clock);
		while (rx_ready !== 1'b1);
		@(posedge clock);
		rx_valid <= 1'b0;
	endtask

	task automatic expect_beats(input string name);
		int w;
		w = 0;
		while (i_net_sink.beats.size() < q.size() && w < 5000)
		begin
			@(negedge clock);
			w++;
		end
		check({name, " count"}, 32'(i_net_sink.beats.size()),
			32'(q.size()));
		foreach (q[k])
			if (k < i_net_sink.beats.size())
				check(name, {23'h0, i_net_sink.beats[k]}, {23'h0, q[k]});
		i_net_sink.beats.delete();
		q.delete();
		$display("test %s done", name);
	endtask

	function automatic logic [31:0] ctrl(input logic [1:0] dp,
		input logic d1e, input logic d2e, input logic [2:0] m,
		input logic [3:0] de);
		return {20'h0_0000, de, 1'b0, m, d2e, d1e, dp};
	endfunction

	task automatic pin_set(input int p, input logic val);
		@(posedge clock);
		if (p == 0)
			dsr <= val;
		else
			dcd <= val;
		repeat (6) @(posedge clock);
		#1;
	endtask

	initial
	begin
		repeat (30000) @(posedge clock);
		n_errors++;
		close_out();
	end

	initial
	begin
		{reset_n, wr, rd, rx_valid, out_act, dsr, dcd, slow} = 8'h00;
		{addr, rx_data, wdata} = 48'h0;
		n_errors = 0;
		cmp_count = 0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		reg_rd(`REG_CTRL, v);
		check("ctrl reset", v, 32'h0000_0100);
		reg_rd(8'h40, v);
		check("unmapped", v, 32'h0000_0000);
		reg_rd(`REG_STATUS, v);
		check("startup open", {31'h0, v[16]}, 32'h0000_0001);
		check("dest_open", {28'h0, dest_open}, 32'h0000_0001);
		reg_wr(`REG_PACK, 32'hFFFF_FFFF);
		reg_rd(`REG_PACK, v);
		check("pack width", v, 32'h0000_07FF);
		reg_wr(`REG_PACK, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			reg_wr(`REG_DEST0 + 8'(4 * i), 32'h0A00_0010 + 32'(i));
			reg_rd(`REG_DEST0 + 8'(4 * i), v);
			check("dest reg", v, 32'h0A00_0010 + 32'(i));
			check("dest port", dest_addr[i], 32'h0A00_0010 + 32'(i));
		end
		$display("test registers done");

		// Zero force time: a byte must wait for the delimiter
		reg_wr(`REG_DELIM, 32'h0000_0A0D);
		reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'd0, 4'h1));
		send(8'h55);
		repeat (100) @(negedge clock);
		check("no timer flush", 32'(i_net_sink.beats.size()), 0);
		send(8'h0D);
		q = '{{8'h55, 1'b0}, {8'h0D, 1'b1}};
		expect_beats("delim nothing");

		reg_wr(`REG_CTRL, ctrl(2'd3, 1'b1, 1'b1, 3'd0, 4'h1));
		q.delete();
		send(8'h41);
		send(8'h0D);
		send(8'h42);
		send(8'h0D);
		send(8'h0A);
		q = '{{8'h41, 1'b0}, {8'h0D, 1'b0}, {8'h42, 1'b1}};
		expect_beats("strip pair");

		for (int k = 1; k <= 2; k++)
		begin
			reg_wr(`REG_CTRL, ctrl(2'(k), 1'b1, 1'b0, 3'd0, 4'h1));
			send(8'h41);
			send(8'h0D);
			q = '{{8'h41, 1'b0}, {8'h0D, 1'b0}};
			for (int j = 0; j < k; j++)
			begin
				send(8'h60 + 8'(j));
				q.push_back({8'h60 + 8'(j), 1'(j == k - 1)});
			end
			expect_beats("delim trail");
		end

		reg_wr(`REG_CTRL, ctrl(2'd0, 1'b0, 1'b0, 3'd0, 4'h1));
		reg_wr(`REG_PACK, 32'h0000_0003);
		slow <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			send(8'h20 + 8'(i));
			q.push_back({8'h20 + 8'(i), 1'(i % 3 == 2)});
		end
		expect_beats("pack length");

		reg_wr(`REG_PACK, 32'h0000_0000);
		// Three ms is far longer than the two-cycle byte spacing used here
		reg_wr(`REG_FORCE, 32'h0000_0003);
		for (int i = 0; i < 3; i++)
		begin
			send(8'h30 + 8'(i));
			q.push_back({8'h30 + 8'(i), 1'(i == 2)});
		end
		repeat (10) @(negedge clock);
		check("held early", 32'(i_net_sink.beats.size()), 0);
		expect_beats("force timer");
		reg_wr(`REG_FORCE, 32'h0000_0000);

		for (int i = 0; i < 1024; i++)
		begin
			send(8'(i));
			q.push_back({8'(i), 1'(i == 1023)});
		end
		// Full frame not yet draining: the last accept must close the input
		#1 check("full refuses", {31'h0, rx_ready}, 0);
		expect_beats("full buffer");
		slow <= 1'b0;

		// Close first through the always-closed code, else opens prove nothing
		reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'd7, 4'hF));
		repeat (2) @(negedge clock);
		check("mode closed", {31'h0, conn_open}, 0);
		reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'd6, 4'hF));
		pin_set(1, 1'b1);
		check("dcd none open", {31'h0, conn_open}, 1);
		pin_set(1, 1'b0);
		check("dcd none held", {31'h0, conn_open}, 1);
		for (int p = 0; p < 2; p++)
		begin
			reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'd7, 4'hF));
			reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'(3 + 2 * p), 4'hF));
			pin_set(p, 1'b1);
			check("pin open", {28'h0, dest_open}, 32'h0000_000F);
			pin_set(p, 1'b0);
			check("pin close", {28'h0, dest_open}, 32'h0000_0000);
		end
		$display("test pins done");

		reg_wr(`REG_INACT, 32'h0000_0004);
		reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'd2, 4'hF));
		@(negedge clock);
		check("idle closed", {31'h0, conn_open}, 0);
		send(8'h0D);
		repeat (4) @(negedge clock);
		check("char opens", {31'h0, conn_open}, 1);
		repeat (20) @(posedge clock);
		out_act <= 1'b1;
		@(posedge clock);
		out_act <= 1'b0;
		repeat (25) @(negedge clock);
		check("activity keeps", {31'h0, conn_open}, 1);
		repeat (60) @(negedge clock);
		check("inactive close", {31'h0, conn_open}, 0);
		reg_wr(`REG_CTRL, ctrl(2'd0, 1'b1, 1'b0, 3'd1, 4'hF));
		send(8'h0D);
		repeat (100) @(negedge clock);
		check("any none held", {31'h0, conn_open}, 1);
		q = '{{8'h0D, 1'b1}, {8'h0D, 1'b1}};
		expect_beats("connection");
		close_out();
	end
endmodule // serial_to_net_packetizer_tb
